// [conv_params.svh]
// conv_params.svh: named constants for the converter timing block and its host
// assumes: included by bare name from the package and both design files
`ifndef CONV_PARAMS_SVH
`define CONV_PARAMS_SVH

// ------------------------------------------------------------
// profile pin codes
// ------------------------------------------------------------
`define PROF_CODE_HS   2'h0
`define PROF_CODE_HR   2'h1
`define PROF_CODE_LP   2'h2
`define PROF_CODE_LS   2'h3

// ------------------------------------------------------------
// master clocks per output word
// ------------------------------------------------------------
`define RATIO_256      12'h100
`define RATIO_512      12'h200
`define RATIO_2560     12'ha00

// ------------------------------------------------------------
// settling lengths in output periods
// ------------------------------------------------------------
`define SETTLE_SPI     8'h81
`define SETTLE_FS      8'h80

// ------------------------------------------------------------
// output protocol select codes
// ------------------------------------------------------------
`define FMT_SPI_LAST   3'h2
`define FMT_FS_FIRST   3'h3
`define FMT_FS_LAST    3'h5
`define FMT_DISC_SPI   3'h2
`define FMT_DISC_FS    3'h5

`define WORD_BITS      24
`define ALIGN_LOW_CYC  4'h4

// ------------------------------------------------------------
// host register map and control fields
// ------------------------------------------------------------
`define REG_CTRL       6'h00
`define REG_ALIGN      6'h04
`define REG_STATUS     6'h08
`define REG_DATA0      6'h10
`define CTRL_RESET     6'h04
`define CTRL_DIV_BIT   2
`define CTRL_FMT_LSB   3
`define STAT_NEW_BIT   0
`define STAT_ALIGN_BIT 1
`define STAT_LIVE_BIT  2

`endif

// [conv_pkg.sv]
// conv_pkg.sv: profile type and ratio/protocol decoding shared by both ends
// assumes: conv_params.svh on the include path
`include "conv_params.svh"

package conv_pkg;

   typedef enum logic [1:0] {PROF_HIGH_SPEED, PROF_HIGH_RES, PROF_LOW_POWER,
                             PROF_LOW_SPEED} profile_t;

   // ---------------------------------------------------------
   // decoding
   // ---------------------------------------------------------
   // map the two profile pins onto a profile
   function automatic profile_t decode_profile(input logic [1:0] code);
      profile_t p;
      p = PROF_HIGH_SPEED;
      case (code)
         `PROF_CODE_HS: p = PROF_HIGH_SPEED;
         `PROF_CODE_HR: p = PROF_HIGH_RES;
         `PROF_CODE_LP: p = PROF_LOW_POWER;
         default:       p = PROF_LOW_SPEED;
      endcase
      return p;
   endfunction

   // master clocks per output word for a profile and divide select
   function automatic logic [11:0] out_ratio(input profile_t p, input logic div);
      logic [11:0] r;
      r = `RATIO_256;
      case (p)
         PROF_HIGH_SPEED: r = `RATIO_256;
         PROF_HIGH_RES:   r = `RATIO_512;
         PROF_LOW_POWER:  r = div ? `RATIO_512 : `RATIO_256;
         default:         r = div ? `RATIO_2560 : `RATIO_512;
      endcase
      return r;
   endfunction

   // framed read-out selected
   function automatic logic is_framed(input logic [2:0] fmt);
      return (fmt >= `FMT_FS_FIRST) && (fmt <= `FMT_FS_LAST);
   endfunction

   // one line per channel instead of one shared line
   function automatic logic is_discrete(input logic [2:0] fmt);
      return (fmt == `FMT_DISC_SPI) || (fmt == `FMT_DISC_FS);
   endfunction

endpackage

// [conv_link_if.sv]
// conv_link_if.sv: pins between converter and host controller
// assumes: both ends clocked by the same master clock
`timescale 1ns/100ps
`default_nettype none

interface conv_link_if #(parameter int NCH = 4);
   logic [1:0]     mode;                // profile select
   logic           clock_divide_select; // clock divide select
   logic [2:0]     format;              // output protocol select
   logic           sync_n;              // conversion align, active low
   logic           sclk;                // shift clock
   logic           frame_clock;         // frame clock, framed protocol
   logic           data_ready_n;        // data ready, active low
   logic [NCH-1:0] dout;                // serial data outputs

   modport dev  (input mode, clock_divide_select, format, sync_n, sclk, frame_clock,
                 output data_ready_n, dout);
   modport host (output mode, clock_divide_select, format, sync_n, sclk, frame_clock,
                 input data_ready_n, dout);
endinterface

`default_nettype wire

// [conv_device.sv]
// conv_device.sv: converter end - profile decode, output rate, settling, align, shifting
// assumes: all link pins synchronous to MCLK, which is also the converter master clock
//
// Overview of operation
// [RULE1] profile pins: HS, HR, LP, LS
// [RULE2] profile pins watched continuously, change acts
// [RULE3] HS 256, HR 512 clocks per word
// [RULE4] divide select picks LP and LS ratio
// [RULE5] all channels share one master clock
// [RULE6] word rate scales with master clock
// [RULE7] host limits master clock per profile
// [RULE8] host uses framed above SPI clock limit
// [RULE9] SPI: ready high until settled, 129 periods
// [RULE10] framed: outputs low until settled, 128 periods
// [RULE11] host takes first one as valid start
// [RULE12] framed latency fixed when change frame-aligned
// [RULE13] align low halts and clears filter counters
// [RULE14] align release restarts conversion from zero
// [RULE15] SPI: ready high on align fall
// [RULE16] framed: outputs low on align fall
// [RULE17] host keeps clocks running around align
// [RULE18] host aligns once after first data
// [RULE19] shared align steps devices together
// [RULE20] protocol chosen by format pins
// [RULE21] count settled periods before data valid
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "conv_params.svh"

module conv_device #(
   parameter int NCH = 4
) (
   conv_link_if.dev                        link,       // pins toward the host
   input  wire logic                       MCLK,       // master clock
   input  wire logic                       RST,        // async reset, high
   input  wire logic [NCH*`WORD_BITS-1:0]  SAMPLE,     // filter result, ch0 on top
   output logic                            CONV_TICK,  // one pulse per output word
   output logic                            DATA_VALID  // settled data present
);

   localparam int SW = NCH * `WORD_BITS;
   localparam int WB = `WORD_BITS;

   // ---------------------------------------------------------
   // pin decode
   // ---------------------------------------------------------
   conv_pkg::profile_t prof;
   logic [11:0]        ratio;
   logic               framed;
   logic               spi;
   logic               discrete;
   logic [1:0]         mode_q;
   logic               div_q;
   logic [2:0]         fmt_q;
   logic               change;
   logic               fclk_q;
   logic               sclk_q;

   // profile and ratio straight from the pins every cycle
   assign prof     = conv_pkg::decode_profile(link.mode);                  // [RULE1]
   assign ratio    = conv_pkg::out_ratio(prof, link.clock_divide_select);  // [RULE3] [RULE4]
   assign framed   = conv_pkg::is_framed(link.format);                     // [RULE20]
   assign spi      = (link.format <= `FMT_SPI_LAST);                       // [RULE20]
   assign discrete = conv_pkg::is_discrete(link.format);
   assign change   = (link.mode != mode_q) || (link.clock_divide_select != div_q)
                     || (link.format != fmt_q);                            // [RULE2]

   // last seen pin levels, for change and edge detection
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         mode_q <= 2'h0;
         div_q  <= 1'b0;
         fmt_q  <= 3'h0;
         fclk_q <= 1'b0;
         sclk_q <= 1'b0;
      end else begin
         mode_q <= link.mode;                                              // [RULE2]
         div_q  <= link.clock_divide_select;
         fmt_q  <= link.format;
         fclk_q <= link.frame_clock;
         sclk_q <= link.sclk;
      end
   end

   // ---------------------------------------------------------
   // conversion timing
   // ---------------------------------------------------------
   logic [11:0] cnt_q;
   logic [7:0]  settle_q;
   logic [7:0]  settle_len;
   logic        tick;
   logic        valid;
   logic [SW-1:0] filt_q;

   // one word per ratio master clocks, halted while align is low
   assign tick = link.sync_n && !change && (cnt_q >= (ratio - 12'h001));  // [RULE3] [RULE6]
   assign settle_len = framed ? `SETTLE_FS : `SETTLE_SPI;                  // [RULE9] [RULE10]
   assign valid = link.sync_n && !change && (settle_q >= settle_len);      // [RULE21]

   // period counter; cleared by align low or a pin change, restarts on release
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         cnt_q <= 12'h000;
      end else if (!link.sync_n || change) begin
         cnt_q <= 12'h000;                                                 // [RULE13] [RULE2]
      end else if (tick) begin
         cnt_q <= 12'h000;
      end else begin
         cnt_q <= cnt_q + 12'h001;                                         // [RULE14] [RULE5]
      end
   end

   // completed periods since the last change or align release
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         settle_q <= 8'h00;
      end else if (!link.sync_n || change) begin
         settle_q <= 8'h00;                                                // [RULE13]
      end else if (tick && (settle_q < settle_len)) begin
         settle_q <= settle_q + 8'h01;                                     // [RULE21]
      end
   end

   // filter result held per period, all channels together
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         filt_q <= '0;
      end else if (!link.sync_n) begin
         filt_q <= '0;                                                     // [RULE13]
      end else if (tick) begin
         filt_q <= SAMPLE;                                                 // [RULE5]
      end
   end

   // ---------------------------------------------------------
   // output shifting
   // ---------------------------------------------------------
   logic          spi_load;
   logic          fs_load;
   logic          shift_en;
   logic          primed_q;
   logic [SW-1:0] shreg_q;
   logic [SW-1:0] shreg_d;
   logic [SW-1:0] shifted;
   logic [NCH-1:0] dout_d;
   logic [NCH-1:0] dout_q;
   logic          data_ready_n_q;
   logic          tick_q;
   logic          valid_q;

   // SPI loads at each settled word, framed at each frame clock rise
   assign spi_load = spi && tick && (settle_q >= settle_len - 8'h01);
   assign fs_load  = framed && link.frame_clock && !fclk_q;                // [RULE12]
   // a fall shifts only once a high was seen after the load
   assign shift_en = primed_q && sclk_q && !link.sclk;

   // shift by one: whole chain for shared line, each word for discrete
   always_comb begin
      shifted = '0;
      for (int k = 0; k < NCH; k++) begin
         shifted[k*WB +: WB] = {shreg_q[k*WB +: WB-1],
                                (!discrete && k > 0) ? shreg_q[k*WB-1] : 1'b0};
      end
   end

   // next shift content
   always_comb begin
      if (!link.sync_n) begin
         shreg_d = '0;                                                     // [RULE16]
      end else if (spi_load) begin
         shreg_d = SAMPLE;
      end else if (fs_load) begin
         shreg_d = valid ? filt_q : '0;                                    // [RULE10]
      end else if (shift_en) begin
         shreg_d = shifted;
      end else begin
         shreg_d = shreg_q;
      end
   end

   // line levels from the next content; framed lines low while unsettled
   always_comb begin
      dout_d = '0;
      for (int k = 0; k < NCH; k++) begin
         if (discrete) begin
            dout_d[k] = shreg_d[SW-1-k*WB];
         end else if (k == 0) begin
            dout_d[k] = shreg_d[SW-1];
         end
      end
      if (framed && !valid) begin
         dout_d = '0;                                                      // [RULE10] [RULE16]
      end
   end

   // shift register and lines
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         shreg_q <= '0;
         dout_q  <= '0;
      end else begin
         shreg_q <= shreg_d;
         dout_q  <= dout_d;
      end
   end

   // shift priming after every load
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         primed_q <= 1'b0;
      end else if (!link.sync_n || spi_load || fs_load) begin
         primed_q <= 1'b0;
      end else if (link.sclk) begin
         primed_q <= 1'b1;
      end
   end

   // data ready: high while unsettled or aligning, low on a fresh word
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         data_ready_n_q <= 1'b1;
      end else if (!link.sync_n || !spi) begin
         data_ready_n_q <= 1'b1;                                                   // [RULE9] [RULE15]
      end else if (spi_load) begin
         data_ready_n_q <= 1'b0;                                                   // [RULE15]
      end else if (!valid || shift_en) begin
         data_ready_n_q <= 1'b1;
      end
   end

   // user-side status
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         tick_q  <= 1'b0;
         valid_q <= 1'b0;
      end else begin
         tick_q  <= tick;
         valid_q <= valid;                                                 // [RULE21]
      end
   end

   assign link.data_ready_n = data_ready_n_q;
   assign link.dout         = dout_q;
   assign CONV_TICK         = tick_q;
   assign DATA_VALID        = valid_q;

endmodule

`default_nettype wire

// [conv_host.sv]
// conv_host.sv: host controller end - drives pins, reads words, Avalon-MM register slave
// assumes: shares MCLK with the converter; reads the shared line, ch0 word first
`timescale 1ns/100ps
`default_nettype none
`include "conv_params.svh"

module conv_host #(
   parameter int NCH = 4
) (
   conv_link_if.host          link,             // pins toward the converter
   input  wire logic          MCLK,             // master clock
   input  wire logic          RST,              // async reset, high
   input  wire logic [5:0]    AVS_ADDRESS,      // byte address
   input  wire logic          AVS_READ,         // read request
   input  wire logic          AVS_WRITE,        // write request
   input  wire logic [31:0]   AVS_WRITEDATA,    // write data
   output logic      [31:0]   AVS_READDATA,     // read data
   output logic               AVS_WAITREQUEST   // stall, high
);

   localparam int SW = NCH * `WORD_BITS;
   localparam int WB = `WORD_BITS;

   logic [5:0]  ctrl_q;
   logic [3:0]  align_cnt_q;
   logic        sync_n_q;
   logic        sclk_q;
   logic        frame_q;
   logic        frame_prev_q;
   logic        data_ready_n_prev_q;
   logic [11:0] pc_q;
   logic        reading_q;
   logic [7:0]  bit_cnt_q;
   logic [SW-1:0] rx_q;
   logic [SW-1:0] rx_d;
   logic [WB-1:0] chan_q [NCH];
   logic        new_q;
   logic        live_q;
   logic        boot_q;
   logic        wait_q;
   logic [31:0] rdata_q;
   logic        framed;
   logic [11:0] ratio;
   logic        start;
   logic        sample;
   logic        done;
   logic        wr_go;
   logic        auto_align;

   // ---------------------------------------------------------
   // decode of own control
   // ---------------------------------------------------------
   assign framed = conv_pkg::is_framed(ctrl_q[`CTRL_FMT_LSB +: 3]);
   assign ratio  = conv_pkg::out_ratio(conv_pkg::decode_profile(ctrl_q[1:0]),
                                       ctrl_q[`CTRL_DIV_BIT]);
   assign start  = !reading_q && (framed ? (frame_q && !frame_prev_q)
                                         : (!link.data_ready_n && data_ready_n_prev_q));
   assign sample = reading_q && sclk_q;
   assign done   = sample && (bit_cnt_q == 8'(SW - 1));
   assign rx_d   = {rx_q[SW-2:0], link.dout[0]};
   assign wr_go  = AVS_WRITE && !wait_q;
   assign auto_align = done && boot_q;                                     // [RULE18]

   // ---------------------------------------------------------
   // link clocks
   // ---------------------------------------------------------
   // frame clock runs continuously in framed protocol, half duty per period
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         pc_q         <= 12'h000;
         frame_q      <= 1'b0;
         frame_prev_q <= 1'b0;
         data_ready_n_prev_q  <= 1'b1;
      end else begin
         pc_q         <= (pc_q >= (ratio - 12'h001)) ? 12'h000 : pc_q + 12'h001;
         frame_q      <= framed && (pc_q < (ratio >> 1));                  // [RULE17]
         frame_prev_q <= frame_q;
         data_ready_n_prev_q  <= link.data_ready_n;
      end
   end

   // shift clock free-running in framed, only while reading in SPI
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         sclk_q <= 1'b0;
      end else if (framed || reading_q) begin
         sclk_q <= !sclk_q;                                                // [RULE17]
      end else begin
         sclk_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------
   // word capture
   // ---------------------------------------------------------
   // sample the shared line while the shift clock is high
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         reading_q <= 1'b0;
         bit_cnt_q <= 8'h00;
         rx_q      <= '0;
      end else if (start) begin
         reading_q <= 1'b1;
         bit_cnt_q <= 8'h00;
      end else if (sample) begin
         rx_q      <= rx_d;
         bit_cnt_q <= bit_cnt_q + 8'h01;
         reading_q <= !done;
      end
   end

   // channel words stored when a whole frame is in
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         for (int k = 0; k < NCH; k++) begin
            chan_q[k] <= '0;
         end
      end else if (done) begin
         for (int k = 0; k < NCH; k++) begin
            chan_q[k] <= rx_d[SW-1-k*WB -: WB];
         end
      end
   end

   // status flags: set wins over a clear in the same cycle
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         new_q  <= 1'b0;
         live_q <= 1'b0;
         boot_q <= 1'b1;
      end else begin
         if (done) begin
            new_q <= 1'b1;
         end else if (wr_go && (AVS_ADDRESS == `REG_STATUS)
                      && AVS_WRITEDATA[`STAT_NEW_BIT]) begin
            new_q <= 1'b0;
         end
         if (sample && link.dout[0]) begin
            live_q <= 1'b1;                                                // [RULE11]
         end else if (!sync_n_q || (wr_go && (AVS_ADDRESS == `REG_CTRL))) begin
            live_q <= 1'b0;
         end
         if (done) begin
            boot_q <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------
   // align pulse
   // ---------------------------------------------------------
   // low for a fixed count of master clocks on request, shared by all devices
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         align_cnt_q <= 4'h0;
         sync_n_q    <= 1'b1;
      end else if ((wr_go && (AVS_ADDRESS == `REG_ALIGN)) || auto_align) begin
         align_cnt_q <= `ALIGN_LOW_CYC;                                    // [RULE19]
         sync_n_q    <= 1'b0;
      end else if (align_cnt_q != 4'h0) begin
         align_cnt_q <= align_cnt_q - 4'h1;
         sync_n_q    <= (align_cnt_q == 4'h1);
      end
   end

   // ---------------------------------------------------------
   // register slave
   // ---------------------------------------------------------
   // control register write; software keeps clock and protocol within limits
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         ctrl_q <= `CTRL_RESET;
      end else if (wr_go && (AVS_ADDRESS == `REG_CTRL)) begin
         ctrl_q <= AVS_WRITEDATA[5:0];                                     // [RULE7] [RULE8]
      end
   end

   // one wait cycle, then the answer stands for one edge
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h00000000;
      end else if ((AVS_READ || AVS_WRITE) && wait_q) begin
         wait_q  <= 1'b0;
         rdata_q <= 32'h00000000;
         if (AVS_ADDRESS == `REG_CTRL) begin
            rdata_q[5:0] <= ctrl_q;
         end else if (AVS_ADDRESS == `REG_STATUS) begin
            rdata_q[`STAT_NEW_BIT]   <= new_q;
            rdata_q[`STAT_ALIGN_BIT] <= !sync_n_q;
            rdata_q[`STAT_LIVE_BIT]  <= live_q;
         end else begin
            for (int k = 0; k < NCH; k++) begin
               if (AVS_ADDRESS == (`REG_DATA0 + 6'(4 * k))) begin
                  rdata_q[WB-1:0] <= chan_q[k];
               end
            end
         end
      end else begin
         wait_q <= 1'b1;
      end
   end

   assign link.mode                = ctrl_q[1:0];
   assign link.clock_divide_select = ctrl_q[`CTRL_DIV_BIT];
   assign link.format              = ctrl_q[`CTRL_FMT_LSB +: 3];
   assign link.sync_n              = sync_n_q;
   assign link.sclk                = sclk_q;
   assign link.frame_clock         = frame_q;
   assign AVS_READDATA             = rdata_q;
   assign AVS_WAITREQUEST          = wait_q;

endmodule

`default_nettype wire

// [conv_link_asserts.sv]
// conv_link_asserts.sv: timing checks on the converter link pins
// assumes: placed beside the link interface, one MCLK domain
`timescale 1ns/100ps
`default_nettype none

module conv_link_asserts #(parameter int NCH = 4) (
   input wire logic           MCLK,                // master clock
   input wire logic           RST,                 // async reset
   input wire logic [1:0]     mode,                // profile pins
   input wire logic           clock_divide_select, // divide select
   input wire logic [2:0]     format,              // protocol select
   input wire logic           sync_n,              // align, low
   input wire logic           data_ready_n,        // ready, low
   input wire logic [NCH-1:0] dout,                // serial data
   input wire logic           CONV_TICK,           // word tick
   input wire logic           DATA_VALID           // settled data
);
   logic [5:0]  cfg_q;
   logic [11:0] cnt_q, rt;
   logic [7:0]  tk_q;
   logic        ok_q;
   wire  [5:0]  cfg = {mode, clock_divide_select, format};
   wire         chg = cfg != cfg_q;
   wire         fr  = format >= 3'h3 && format <= 3'h5;
   wire  [7:0]  st  = fr ? 8'h80 : 8'h81;

   // expected clocks per word for the pins
   always_comb begin
      case (mode)
         2'h0: rt = 12'h100;
         2'h1: rt = 12'h200;
         2'h2: rt = clock_divide_select ? 12'h200 : 12'h100;
         default: rt = clock_divide_select ? 12'ha00 : 12'h200;
      endcase
   end

   // cycles since tick, ticks since change or align
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         cfg_q <= 6'h08;
         cnt_q <= 12'h0;
         tk_q  <= 8'h0;
         ok_q  <= 1'b0;
      end else begin
         cfg_q <= cfg;
         cnt_q <= CONV_TICK ? 12'h0 : cnt_q + 12'h1;
         ok_q  <= (chg || !sync_n) ? 1'b0 : (CONV_TICK ? 1'b1 : ok_q);
         tk_q  <= (chg || !sync_n) ? 8'h0 : tk_q + {7'h0, CONV_TICK && tk_q != 8'hff};
      end
   end

   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);
   sequence quiet;
      !CONV_TICK [*8];
   endsequence

   AST_RATE: assert property (ok_q && !chg && sync_n |-> CONV_TICK == (cnt_q == rt - 12'h1))
      else $error("word tick off its period");
   AST_SETTLE: assert property ($rose(DATA_VALID) |-> tk_q >= st - 8'h1 && tk_q <= st)
      else $error("valid after wrong settle count");
   AST_DATA_READY_N_FALL: assert property ($fell(data_ready_n) |-> tk_q >= 8'h80)
      else $error("ready before settling");
   AST_SYNC_DATA_READY_N: assert property (!sync_n |=> data_ready_n)
      else $error("ready low during align");
   AST_SYNC_DOUT: assert property (!sync_n |=> dout == '0)
      else $error("data during align");
   AST_RESTART: assert property ($rose(sync_n) |-> quiet)
      else $error("tick right after align release");
   AST_CHANGE: assert property (chg |-> ##[1:2] !DATA_VALID)
      else $error("pin change not acted on");
   AST_FR_DATA_READY_N: assert property (fr && $past(fr) |-> data_ready_n)
      else $error("ready low in framed read-out");
   AST_FR_ZERO: assert property (fr && !DATA_VALID && !$past(DATA_VALID) |-> dout == '0)
      else $error("framed data before settling");
endmodule

`default_nettype wire

// [tb.sv]
// tb.sv: both link ends joined, host registers driven over Avalon-MM
// assumes: design files and the checker compiled first
`timescale 1ns/100ps
`default_nettype none

module tb;
   logic        mclk = 1'b0, rst = 1'b1, rq = 1'b0, wq = 1'b0, tick, valid, wreq;
   logic [5:0]  adr = 6'h0;
   logic [31:0] wd = 32'h0, rdat, s;
   logic [95:0] smp = 96'ha5c3f1_5a3c0f_123456_fedcba;
   logic [5:0]  cf[6] = '{6'h04, 6'h05, 6'h06, 6'h02, 6'h07, 6'h03};
   int          rt[6] = '{256, 512, 512, 256, 2560, 512};
   int          err_count = 0, cmp_count = 0, cyc = 0;

   conv_link_if #(.NCH(4)) i_conv_link_if ();
   conv_device #(.NCH(4)) i_conv_device (.link(i_conv_link_if), .MCLK(mclk), .RST(rst),
      .SAMPLE(smp), .CONV_TICK(tick), .DATA_VALID(valid));
   conv_host #(.NCH(4)) i_conv_host (.link(i_conv_link_if), .MCLK(mclk), .RST(rst),
      .AVS_ADDRESS(adr), .AVS_READ(rq), .AVS_WRITE(wq), .AVS_WRITEDATA(wd),
      .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq));
   conv_link_asserts #(.NCH(4)) i_conv_link_asserts (.MCLK(mclk), .RST(rst),
      .mode(i_conv_link_if.mode), .clock_divide_select(i_conv_link_if.clock_divide_select),
      .format(i_conv_link_if.format), .sync_n(i_conv_link_if.sync_n),
      .data_ready_n(i_conv_link_if.data_ready_n), .dout(i_conv_link_if.dout),
      .CONV_TICK(tick), .DATA_VALID(valid));

   // clock and cycle count
   always #2 mclk = ~mclk;
   always @(posedge mclk) cyc <= cyc + 1;

   // ----------------------------------------
   // bus tasks
   // ----------------------------------------
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge mclk);
      adr <= a;
      wd  <= d;
      wq  <= 1'b1;
      do @(posedge mclk); while (wreq !== 1'b0);
      wq <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, output logic [31:0] d);
      @(posedge mclk);
      adr <= a;
      rq  <= 1'b1;
      do @(posedge mclk); while (wreq !== 1'b0);
      d  = rdat;
      rq <= 1'b0;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask

   // profile change, wait for first settled word, check timing and words
   task automatic settle(input logic [5:0] c, input int n, input logic al);
      int t0;
      wr(6'h00, {26'h0, c});
      t0 = cyc;
      if (al)
         wr(6'h04, 32'h1);
      wr(6'h08, 32'h1);
      s = 32'h0;
      while (s[al ? 2 : 0] !== 1'b1) rd(6'h08, s);
      chk(32'(cyc - t0 >= n * 256 && cyc - t0 <= n * 256 + 300), 32'h1);
      repeat (200) @(posedge mclk);
      rd(6'h08, s);
      chk(s & 32'h5, al ? 32'h5 : 32'h1);
      for (int k = 0; k < 4; k++) begin
         rd(6'h10 + 6'(4 * k), s);
         chk(s, {8'h0, smp[95 - 24 * k -: 24]});
      end
   endtask

   task print_verdict;
      if (err_count == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      rd(6'h00, s);
      chk(s, 32'h4);
      rd(6'h3c, s);
      chk(s, 32'h0);
      wr(6'h3c, 32'h7);
      for (int i = 0; i < 6; i++) begin
         wr(6'h00, {26'h0, cf[i]});
         rd(6'h00, s);
         chk(s, {26'h0, cf[i]});
         repeat (3 * rt[i]) @(posedge mclk);
      end
      settle(6'h04, 129, 1'b0);
      settle(6'h1c, 128, 1'b1);
      print_verdict;
   end

   // watchdog
   initial begin
      repeat (100000) @(posedge mclk);
      err_count++;
      print_verdict;
   end
endmodule

`default_nettype wire
